// *** hdl/bir_router.sv ***
`timescale 1ns/100ps
`default_nettype none
module bir_router
	import bir_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic clk_en,
	// register port, shared by both bus sides upstream
	input wire logic reg_sel,
	input wire logic reg_wr,
	input wire logic [11:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	output logic [31:0] reg_rdata,
	// event conditions, bit-aligned to status layout (level inputs)
	input wire logic [31:0] src_cond,
	// message queue levels, inbound post push strobe and out-post mask
	input wire logic out_post_nonempty,
	input wire logic in_free_empty,
	input wire logic out_free_empty,
	input wire logic in_post_full,
	input wire logic out_free_full,
	input wire logic in_post_push,
	input wire logic out_post_mask,
	// interrupt outputs, active high
	output logic local_irq_out,
	output logic pci_irq_out
);
	// ----------------------------------------------------------------
	// reset release
	// ----------------------------------------------------------------
	logic [1:0] rst_sync_r;
	logic rst_n;
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rst_sync_r <= 2'b00;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_r[1];

	// ----------------------------------------------------------------
	// register decode
	// ----------------------------------------------------------------
	logic wr_status, wr_enable, wr_route, wr_soft_up;
	assign wr_status = reg_sel && reg_wr && reg_addr == BIR_OFS_STATUS;
	assign wr_enable = reg_sel && reg_wr && reg_addr == BIR_OFS_ENABLE;
	assign wr_route = reg_sel && reg_wr && reg_addr == BIR_OFS_ROUTE;
	assign wr_soft_up = reg_sel && reg_wr && reg_addr == BIR_OFS_SOFT_UP;

	// ----------------------------------------------------------------
	// enable and route registers
	// ----------------------------------------------------------------
	logic [31:0] enable_r, route_r, enable_eff, route_eff;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			enable_r <= BIR_ZERO;
		end else if (clk_en && wr_enable) begin
			enable_r <= reg_wdata & BIR_ENABLE_WMASK;
		end
	end
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			route_r <= BIR_ZERO;
		end else if (clk_en && wr_route) begin
			route_r <= reg_wdata & BIR_ROUTE_WMASK;
		end
	end
	// mirror bit is wired, not stored, so it never lags the message unit
	always_comb begin
		enable_eff = enable_r;
		enable_eff[BIR_B_OUT_POST_NE] = out_post_mask;
	end
	assign route_eff = (route_r & BIR_ROUTE_WMASK) | BIR_ROUTE_FIXED1;

	// ----------------------------------------------------------------
	// event edge detection and set terms
	// ----------------------------------------------------------------
	logic [31:0] cond_d_r, set_vec, clr_vec, sticky_q;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cond_d_r <= BIR_ZERO;
		end else if (clk_en) begin
			cond_d_r <= src_cond;
		end
	end
	always_comb begin
		// rising condition sets; source flags are never touched here
		set_vec = src_cond & ~cond_d_r & BIR_EVENT_MASK & ~BIR_SOFT_HI_MASK & ~BIR_SOFT_LO_MASK;
		// master parity: only while enabled
		set_vec[BIR_B_MASTER_PAR] = src_cond[BIR_B_MASTER_PAR] && !cond_d_r[BIR_B_MASTER_PAR]
			&& enable_eff[BIR_B_MASTER_PAR];
		// new entry: only on a push while enabled
		set_vec[BIR_B_IN_POST_NEW] = in_post_push && enable_eff[BIR_B_IN_POST_NEW];
		if (wr_enable) begin
			set_vec = set_vec | (reg_wdata & BIR_SOFT_LO_MASK);
		end
		if (wr_soft_up) begin
			set_vec = set_vec | (reg_wdata & BIR_SOFT_HI_MASK);
		end
		clr_vec = wr_status ? (reg_wdata & BIR_EVENT_MASK) : BIR_ZERO;
	end

	// ----------------------------------------------------------------
	// sticky status bits
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < 32; gi++) begin : g_bit
			if (BIR_EVENT_MASK[gi]) begin : g_st
				bir_sticky u_st (
					.sys_clk(sys_clk),
					.rst_n(rst_n),
					.ce(clk_en),
					.set_pulse(set_vec[gi]),
					.clr_pulse(clr_vec[gi]),
					.flag_r(sticky_q[gi])
				);
			end else begin : g_no
				assign sticky_q[gi] = 1'b0;
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// queue level bits, registered with documented reset values
	// ----------------------------------------------------------------
	logic [31:0] level_r, level_nxt;
	always_comb begin
		level_nxt = BIR_ZERO;
		level_nxt[BIR_B_OUT_POST_NE] = out_post_nonempty;
		level_nxt[BIR_B_IN_FREE_E] = in_free_empty;
		level_nxt[BIR_B_OUT_FREE_E] = out_free_empty;
		level_nxt[BIR_B_IN_POST_F] = in_post_full;
		level_nxt[BIR_B_OUT_FREE_F] = out_free_full;
	end
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			level_r <= BIR_STATUS_RST;
		end else if (clk_en) begin
			level_r <= level_nxt;
		end
	end

	logic [31:0] status_all;
	assign status_all = sticky_q | (level_r & BIR_LEVEL_MASK);

	// ----------------------------------------------------------------
	// interrupt outputs
	// ----------------------------------------------------------------
	logic [31:0] armed;
	logic local_nxt, pci_nxt;
	assign armed = status_all & enable_eff;
	assign local_nxt = |(armed & ~route_eff);
	assign pci_nxt = |(armed & route_eff);
	// registered so the pins never glitch on decode
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			local_irq_out <= 1'b0;
			pci_irq_out <= 1'b0;
		end else if (clk_en) begin
			local_irq_out <= local_nxt;
			pci_irq_out <= pci_nxt;
		end
	end

	// ----------------------------------------------------------------
	// read data; soft trigger bits read zero in the enable and upper trigger words, not in status
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= BIR_ZERO;
		end else if (clk_en) begin
			unique case (reg_addr)
				BIR_OFS_STATUS: reg_rdata <= status_all;
				BIR_OFS_ENABLE: reg_rdata <= enable_eff & ~BIR_SOFT_LO_MASK;
				BIR_OFS_ROUTE: reg_rdata <= route_eff;
				default: reg_rdata <= BIR_ZERO;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	edge_sets_a: assert property (clk_en && src_cond[BIR_B_PCI_IRQ] && !cond_d_r[BIR_B_PCI_IRQ]
		|=> status_all[BIR_B_PCI_IRQ]) else $error("rising source did not set status");
	hold_set_a: assert property (clk_en && status_all[BIR_B_SYSERR] && !clr_vec[BIR_B_SYSERR]
		|=> status_all[BIR_B_SYSERR]) else $error("status dropped without clear");
	clear_one_a: assert property (clk_en && wr_status && reg_wdata[BIR_B_LOC_IRQ] && !set_vec[BIR_B_LOC_IRQ]
		|=> !status_all[BIR_B_LOC_IRQ]) else $error("write one did not clear");
	mpar_gate_a: assert property (clk_en && !enable_eff[BIR_B_MASTER_PAR] && !status_all[BIR_B_MASTER_PAR]
		|=> !status_all[BIR_B_MASTER_PAR]) else $error("master parity set while disabled");
	level_follow_a: assert property (clk_en |=> status_all[BIR_B_IN_FREE_E] == $past(in_free_empty))
		else $error("free empty not following queue");
	newentry_gate_a: assert property (clk_en && in_post_push && enable_eff[BIR_B_IN_POST_NEW]
		|=> status_all[BIR_B_IN_POST_NEW]) else $error("new entry not latched");
	route_fixed_a: assert property (route_eff[BIR_B_LOC_IRQ] && route_eff[BIR_B_OUT_POST_NE]
		&& !route_eff[BIR_B_PCI_IRQ] && !route_eff[BIR_B_POWER]) else $error("fixed route wrong");
	mirror_a: assert property (enable_eff[BIR_B_OUT_POST_NE] == out_post_mask)
		else $error("mirror enable wrong");
	soft_set_a: assert property (clk_en && wr_soft_up && reg_wdata[3] |=> status_all[3])
		else $error("soft trigger three did not set");
	out_map_a: assert property (clk_en |=> local_irq_out == $past(|(armed & ~route_eff)))
		else $error("local output mismatch");
	no_enable_a: assert property (clk_en && enable_eff == BIR_ZERO |=> !local_irq_out && !pci_irq_out)
		else $error("output without enable");
	enable_rst_a: assert property ($rose(rst_n) |-> enable_r == BIR_ZERO)
		else $error("enables not cleared");

	pci_fwd_c: cover property (local_irq_out && status_all[BIR_B_PCI_IRQ]);
	loc_fwd_c: cover property (pci_irq_out && status_all[BIR_B_LOC_IRQ]);
	set_clear_c: cover property (set_vec[BIR_B_SYSERR] && clr_vec[BIR_B_SYSERR]);
	soft_c: cover property (wr_enable && reg_wdata[0]);
	ope_pci_c: cover property (pci_irq_out && status_all[BIR_B_OUT_POST_NE]);

	// ----------------------------------------------------------------
	// queue levels and reset values
	// ----------------------------------------------------------------
	// levels lag the queue by one register stage, never by their enables
	level_ope_a: assert property (clk_en |=> status_all[BIR_B_OUT_POST_NE] == $past(out_post_nonempty))
		else $error("out post nonempty not following queue");
	level_ofe_a: assert property (clk_en |=> status_all[BIR_B_OUT_FREE_E] == $past(out_free_empty))
		else $error("out free empty not following queue");
	level_ipf_a: assert property (clk_en |=> status_all[BIR_B_IN_POST_F] == $past(in_post_full))
		else $error("in post full not following queue");
	level_off_a: assert property (clk_en |=> status_all[BIR_B_OUT_FREE_F] == $past(out_free_full))
		else $error("out free full not following queue");
	status_rst_a: assert property ($rose(rst_n) |-> status_all == BIR_STATUS_RST)
		else $error("status reset value wrong");
	route_rst_a: assert property ($rose(rst_n) |-> route_eff == BIR_ROUTE_FIXED1)
		else $error("route reset value wrong");
	out_rst_a: assert property ($rose(rst_n) |-> !local_irq_out && !pci_irq_out)
		else $error("outputs active after reset");

	// ----------------------------------------------------------------
	// register writes, holds and reads
	// ----------------------------------------------------------------
	route_ro_a: assert property ((route_eff & ~BIR_ROUTE_WMASK & ~BIR_ROUTE_FIXED1) == BIR_ZERO)
		else $error("fixed zero route bit set");
	enable_write_a: assert property (clk_en && wr_enable |=> enable_r == ($past(reg_wdata) & BIR_ENABLE_WMASK))
		else $error("enable write wrong");
	route_write_a: assert property (clk_en && wr_route |=> route_r == ($past(reg_wdata) & BIR_ROUTE_WMASK))
		else $error("route write wrong");
	enable_hold_a: assert property (!(clk_en && wr_enable) |=> $stable(enable_r))
		else $error("enable changed without write");
	route_hold_a: assert property (!(clk_en && wr_route) |=> $stable(route_r))
		else $error("route changed without write");
	// a frozen clock enable must hold every status bit as well
	freeze_a: assert property (!clk_en |=> $stable(status_all) && $stable(reg_rdata))
		else $error("state moved while frozen");
	status_read_a: assert property (clk_en && reg_addr == BIR_OFS_STATUS |=> reg_rdata == $past(status_all))
		else $error("status read wrong");
	soft_lo_read_a: assert property (clk_en && reg_addr == BIR_OFS_ENABLE |=> reg_rdata[1:0] == 2'b00)
		else $error("soft trigger bits read nonzero");
	soft_hi_read_a: assert property (clk_en && reg_addr == BIR_OFS_SOFT_UP |=> reg_rdata == BIR_ZERO)
		else $error("upper trigger word read nonzero");

	// ----------------------------------------------------------------
	// event setting
	// ----------------------------------------------------------------
	soft_zero_a: assert property (clk_en && wr_enable && reg_wdata[0] |=> status_all[0])
		else $error("soft trigger zero did not set");
	soft_one_a: assert property (clk_en && wr_enable && reg_wdata[1] |=> status_all[1])
		else $error("soft trigger one did not set");
	soft_two_a: assert property (clk_en && wr_soft_up && reg_wdata[2] |=> status_all[2])
		else $error("soft trigger two did not set");
	loc_edge_a: assert property (clk_en && src_cond[BIR_B_LOC_IRQ] && !cond_d_r[BIR_B_LOC_IRQ]
		|=> status_all[BIR_B_LOC_IRQ]) else $error("local irq input not latched");
	serr_edge_a: assert property (clk_en && src_cond[BIR_B_SYSERR] && !cond_d_r[BIR_B_SYSERR]
		|=> status_all[BIR_B_SYSERR]) else $error("syserr not latched");
	par_edge_a: assert property (clk_en && src_cond[BIR_B_PCI_PAR] && !cond_d_r[BIR_B_PCI_PAR]
		|=> status_all[BIR_B_PCI_PAR]) else $error("parity error not latched");
	power_edge_a: assert property (clk_en && src_cond[BIR_B_POWER] && !cond_d_r[BIR_B_POWER]
		|=> status_all[BIR_B_POWER]) else $error("power change not latched");
	// the condition line of the new entry bit is ignored, only a push counts
	newentry_only_a: assert property (clk_en && !in_post_push && !status_all[BIR_B_IN_POST_NEW]
		|=> !status_all[BIR_B_IN_POST_NEW]) else $error("new entry set without push");

	// ----------------------------------------------------------------
	// output mapping
	// ----------------------------------------------------------------
	pci_map_a: assert property (clk_en |=> pci_irq_out == $past(|(armed & route_eff)))
		else $error("pci output mismatch");
	pci_to_loc_a: assert property (clk_en && status_all[BIR_B_PCI_IRQ] && enable_eff[BIR_B_PCI_IRQ]
		|=> local_irq_out) else $error("pci irq not forwarded");
	loc_to_pci_a: assert property (clk_en && status_all[BIR_B_LOC_IRQ] && enable_eff[BIR_B_LOC_IRQ]
		|=> pci_irq_out) else $error("local irq not forwarded");
	serr_to_loc_a: assert property (clk_en && status_all[BIR_B_SYSERR] && enable_eff[BIR_B_SYSERR]
		|=> local_irq_out) else $error("syserr not mapped");
	par_to_loc_a: assert property (clk_en && status_all[BIR_B_PCI_PAR] && enable_eff[BIR_B_PCI_PAR]
		|=> local_irq_out) else $error("parity error not mapped");
	ope_to_pci_a: assert property (clk_en && status_all[BIR_B_OUT_POST_NE] && out_post_mask
		|=> pci_irq_out) else $error("out post nonempty not on pci");
	idle_out_a: assert property (clk_en && (status_all & enable_eff) == BIR_ZERO
		|=> !local_irq_out && !pci_irq_out) else $error("output without armed status");
endmodule
`default_nettype wire

// *** hdl/bir_pkg.sv ***
package bir_pkg;
	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [11:0] BIR_OFS_STATUS = 12'h600;
	localparam logic [11:0] BIR_OFS_ENABLE = 12'h604;
	localparam logic [11:0] BIR_OFS_ROUTE = 12'h608;
	localparam logic [11:0] BIR_OFS_SOFT_UP = 12'h60C;
	// ----------------------------------------------------------------
	// field positions (same bit in status, enable and route)
	// ----------------------------------------------------------------
	localparam int BIR_B_PCI_IRQ = 23;
	localparam int BIR_B_PCI_PAR = 22;
	localparam int BIR_B_SYSERR = 21;
	localparam int BIR_B_LOC_IRQ = 20;
	localparam int BIR_B_MASTER_PAR = 29;
	localparam int BIR_B_POWER = 14;
	localparam int BIR_B_OUT_POST_NE = 13;
	localparam int BIR_B_IN_POST_NEW = 12;
	localparam int BIR_B_IN_FREE_E = 11;
	localparam int BIR_B_OUT_FREE_E = 10;
	localparam int BIR_B_IN_POST_F = 9;
	localparam int BIR_B_OUT_FREE_F = 8;
	// ----------------------------------------------------------------
	// bit groups
	// ----------------------------------------------------------------
	// sticky event bits: all of 31..8 except the five queue levels, plus soft 3..0
	localparam logic [31:0] BIR_EVENT_MASK = 32'hFFFF_F00F & ~32'h0000_2000;
	// five queue level bits follow queue state directly
	localparam logic [31:0] BIR_LEVEL_MASK = 32'h0000_2F00;
	// software triggers: bits 1,0 in enable reg, bits 3,2 in upper trigger reg
	localparam logic [31:0] BIR_SOFT_LO_MASK = 32'h0000_0003;
	localparam logic [31:0] BIR_SOFT_HI_MASK = 32'h0000_000C;
	// writable enable bits (out-post-nonempty enable is a mirror)
	localparam logic [31:0] BIR_ENABLE_WMASK = 32'hFFFF_DF00;
	// writable route bits; fixed zero and fixed one sets
	localparam logic [31:0] BIR_ROUTE_WMASK = 32'hFF0F_8F0F;
	localparam logic [31:0] BIR_ROUTE_FIXED1 = 32'h0010_2000;
	// reset values
	localparam logic [31:0] BIR_STATUS_RST = 32'h0000_0C00;
	localparam logic [31:0] BIR_ZERO = 32'h0000_0000;
endpackage

// *** hdl/bir_sticky.sv ***
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// one sticky write-one-to-clear status bit
// ----------------------------------------------------------------
module bir_sticky (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic set_pulse,
	input wire logic clr_pulse,
	output logic flag_r
);
	// set wins over clear so an event in the clearing cycle survives
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			flag_r <= 1'b0;
		end else if (ce) begin
			if (set_pulse) begin
				flag_r <= 1'b1;
			end else if (clr_pulse) begin
				flag_r <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// *** sim/bir_src_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// originating unit: holds its own status flag per source
// ----------------------------------------------------------------
module bir_src_model (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic [31:0] raise,
	input wire logic [31:0] clear,
	output logic [31:0] flag_r
);
	// flag stays up until its own unit is written, not the router's status
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			flag_r <= 32'h0000_0000;
		end else begin
			flag_r <= (flag_r | raise) & ~clear;
		end
	end
endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// bench for the interrupt router
// ----------------------------------------------------------------
module tb_top;
	import bir_pkg::*;
	logic sys_clk = 1'b0, rstn = 1'b0, clk_en = 1'b1, reg_sel = 1'b0, reg_wr = 1'b0;
	logic in_post_push = 1'b0, out_post_mask = 1'b0, rd_seen = 1'b0;
	logic local_irq_out, pci_irq_out, en, dir, eff, st;
	logic [11:0] reg_addr = 12'h000;
	logic [31:0] reg_wdata = 32'h0, raise = 32'h0, clear = 32'h0, src_cond, reg_rdata;
	logic [31:0] seed = 32'h2951E140;
	logic [4:0] q = 5'b00110; // free lists start empty
	logic [31:0] exp_q[$];
	int miscompares = 0, tests_run = 0, cycles = 0, b;
	int ev_bits[19] = '{31, 30, 29, 28, 27, 26, 25, 24, 23, 22, 21, 20, 19, 18, 17, 16, 15, 14, 12};

	always #12.5 sys_clk = ~sys_clk;

	bir_router u_bir_router (.sys_clk, .rstn, .clk_en, .reg_sel, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata,
		.src_cond, .out_post_nonempty(q[0]), .in_free_empty(q[1]), .out_free_empty(q[2]),
		.in_post_full(q[3]), .out_free_full(q[4]), .in_post_push, .out_post_mask, .local_irq_out, .pci_irq_out);
	bir_src_model u_bir_src_model (.sys_clk, .rstn, .raise, .clear, .flag_r(src_cond));

	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	// queue levels as they should show in the status word
	function automatic logic [31:0] lvl();
		return 32'({q[0], 1'b0, q[1], q[2], q[3], q[4]}) << 8;
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_sim();
		if (miscompares == 0 && tests_run > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	// one register cycle; request held across exactly one sampling edge
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		#2 {reg_sel, reg_wr, reg_addr, reg_wdata} = {1'b1, w, a, d};
		@(posedge sys_clk);
		#2 reg_sel = 1'b0;
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		exp_q.push_back(exp);
		bus(1'b0, a, 32'h0);
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#2;
	endtask

	// read data lands on the edge that takes the read; compare half a cycle on
	always @(posedge sys_clk) rd_seen <= reg_sel & ~reg_wr;
	always @(negedge sys_clk) if (rd_seen) check(reg_rdata, exp_q.pop_front());

	// hang guard, run needs well under this
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			end_sim();
		end
	end

	initial begin
		tick(6);
		rstn = 1'b1;
		tick(4);
		rd(BIR_OFS_STATUS, BIR_STATUS_RST);
		rd(BIR_OFS_ENABLE, BIR_ZERO);
		rd(BIR_OFS_ROUTE, BIR_ROUTE_FIXED1);
		rd(BIR_OFS_SOFT_UP, BIR_ZERO);
		rd(12'h610, BIR_ZERO);
		bus(1'b1, BIR_OFS_ROUTE, 32'hFFFF_FFFF);
		rd(BIR_OFS_ROUTE, BIR_ROUTE_WMASK | BIR_ROUTE_FIXED1);
		bus(1'b1, BIR_OFS_ENABLE, 32'hFFFF_FFFC);
		rd(BIR_OFS_ENABLE, BIR_ENABLE_WMASK);
		bus(1'b1, BIR_OFS_ENABLE, BIR_ZERO);
		bus(1'b1, BIR_OFS_ROUTE, BIR_ZERO);
		// software triggers: low pair via enable word, high pair via upper word
		for (int k = 0; k < 4; k++) begin
			bus(1'b1, (k < 2) ? BIR_OFS_ENABLE : BIR_OFS_SOFT_UP, 32'h1 << k);
			rd(BIR_OFS_STATUS, lvl() | (32'h1 << k));
			rd((k < 2) ? BIR_OFS_ENABLE : BIR_OFS_SOFT_UP, BIR_ZERO);
			bus(1'b1, BIR_OFS_STATUS, 32'h1 << k);
		end
		// random source, enable, route and queue levels per pass
		repeat (14) begin
			seed = xs(seed);
			b = ev_bits[seed % 19];
			{q, dir, en} = seed[14:8];
			eff = (b inside {23, 22, 21, 14, 12}) ? 1'b0 : (b == 20) ? 1'b1 : dir;
			st = (b == 29 || b == 12) ? en : 1'b1;
			bus(1'b1, BIR_OFS_ENABLE, 32'(en) << b);
			bus(1'b1, BIR_OFS_ROUTE, 32'(dir) << b);
			if (b == 12) in_post_push = 1'b1;
			else raise[b] = 1'b1;
			tick(1);
			{in_post_push, raise} = '0;
			tick(3);
			rd(BIR_OFS_STATUS, lvl() | (32'(st) << b));
			check(local_irq_out, st & en & ~eff);
			check(pci_irq_out, st & en & eff);
			bus(1'b1, BIR_OFS_STATUS, BIR_ZERO);
			rd(BIR_OFS_STATUS, lvl() | (32'(st) << b));
			bus(1'b1, BIR_OFS_STATUS, 32'h1 << b);
			rd(BIR_OFS_STATUS, lvl());
			check(src_cond[b], b != 12);
			clear[b] = 1'b1;
			tick(1);
			clear = '0;
			tick(2);
			check({local_irq_out, pci_irq_out}, 2'b00);
		end
		// last pass leaves its enable and route behind; clear them first
		bus(1'b1, BIR_OFS_ENABLE, BIR_ZERO);
		bus(1'b1, BIR_OFS_ROUTE, BIR_ZERO);
		// clock enable low: a write must not land
		clk_en = 1'b0;
		bus(1'b1, BIR_OFS_ENABLE, 32'h0080_0000);
		clk_en = 1'b1;
		rd(BIR_OFS_ENABLE, BIR_ZERO);
		// out-post enable mirrors the message unit mask, routed to PCI
		q = 5'b00111;
		out_post_mask = 1'b1;
		tick(2);
		rd(BIR_OFS_ENABLE, 32'h0000_2000);
		tick(2);
		check({local_irq_out, pci_irq_out}, 2'b01);
		tick(4);
		end_sim();
	end
endmodule
`default_nettype wire
